// [tsc_map.svh]
// register map and field positions of the timer synchronous control block
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

`define TSC_ADDR_STRB       8'h95
`define TSC_PAGE_START      4'h1
`define TSC_PAGE_RELOAD     4'h2
`define TSC_PAGE_STOP       4'h3

`define TSC_BIT_T0          0
`define TSC_BIT_T1          1
`define TSC_BIT_T2          2
`define TSC_BIT_T2L         5

`define TSC_RST_STRB        8'h00
`define TSC_RST_RUN         4'h0

`endif

// [tsc_pkg.sv]
// types of the timer synchronous control block
package tsc_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsc_sfr_req_t;

  // run bits: [0] t0, [1] t1, [2] t2, [3] t2 low half
  typedef struct packed {
    logic [3:0] run;
  } tsc_run_t;

  // reload pulses: [0] t0 both, [1] t1 both, [2] t2 high (or both), [3] t2 low
  typedef struct packed {
    logic [3:0] reload;
  } tsc_reload_t;

  typedef struct packed {
    tsc_run_t    run;
    tsc_reload_t rld;
    logic        t2_low_gate;
    logic        t2_high_gate;
    logic [7:0]  rdata;
  } tsc_state_t;

endpackage

// [tsc_timer_model.sv]
// behavioural timer 0 and timer 2 counters standing behind the sync control block
`timescale 1ns/1ps

module tsc_timer_model
  import tsc_pkg::*;
#(
  parameter logic [15:0] RLD_VAL = 16'h1234
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire tsc_run_t    i_run,
  input  wire tsc_reload_t i_reload,
  input  wire logic        i_split,
  input  wire logic        i_low_gate,
  input  wire logic        i_high_gate,
  output logic [15:0]      o_cnt_t0,
  output logic [15:0]      o_cnt_t2
);
  // reload wins over counting, like an overflow reload; run bits untouched
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cnt_t0 <= 16'h0000;
      o_cnt_t2 <= 16'h0000;
    end else begin
      if (i_reload.reload[0]) o_cnt_t0 <= RLD_VAL;
      else if (i_run.run[0]) o_cnt_t0 <= o_cnt_t0 + 16'h0001;
      // split: two independent bytes, each with its own gate
      if (i_reload.reload[3] || (i_reload.reload[2] && !i_split)) o_cnt_t2[7:0] <= RLD_VAL[7:0];
      else if (i_low_gate) o_cnt_t2[7:0] <= o_cnt_t2[7:0] + 8'h01;
      if (i_reload.reload[2]) o_cnt_t2[15:8] <= RLD_VAL[15:8];
      else if (i_high_gate && (i_split || o_cnt_t2[7:0] == 8'hFF)) o_cnt_t2[15:8] <= o_cnt_t2[15:8] + 8'h01;
    end
  end
endmodule

// [tsc_timer_sync.sv]
// synchronous start, reload and stop strobes for timers 0, 1 and 2
//
// Overview of operation
// R1: writing one to start strobe bit 0 sets the timer-0 run bit.
// R2: writing one to start strobe bit 1 sets the timer-1 run bit.
// R3: writing one to start strobe bit 2 sets the timer-2 run bit.
// R4: in split mode, start strobe bit 5 sets the timer-2 low half run bit.
// R5: all strobe bits clear themselves; they never stay set.
// R6: a written zero in any strobe bit changes nothing.
// R7: several start strobes in one write start those timers together.
// R8: software writes zero to bits 7-6 and 4-3 of the start register.
// R9: software writes zero to bits 7-6 and 4-3 of reload and stop registers.
// R10: in split mode, reload strobe bit 5 forces a timer-2 low byte reload.
// R11: reload bit 2 reloads both timer-2 bytes, or only high byte when split.
// R12: timer-2 forced reloads are ignored in duty capture mode.
// R13: reload strobe bit 1 forces a reload of both timer-1 bytes.
// R14: reload strobe bit 0 forces a reload of both timer-0 bytes.
// R15: in split mode, stop strobe bit 5 clears the timer-2 low half run bit.
// R16: stop strobe bit 2 clears the timer-2 run bit.
// R17: stop strobe bit 1 clears the timer-1 run bit.
// R18: stop strobe bit 0 clears the timer-0 run bit.
// R19: when split, low half run bit gates low byte, timer-2 run bit high byte.
// R20: when split, the timer-2 run bit gates only the high byte counter.
// R21: forced reload acts like an overflow reload and leaves run bits alone.
// R22: reading any strobe register returns zero.
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_timer_sync
  import tsc_pkg::*;
(
  input  wire logic         I_CLK_SYS,
  input  wire logic         I_SYS_RST,
  input  wire tsc_sfr_req_t I_SFR_REQ,
  input  wire logic         I_T2_SPLIT,
  input  wire logic         I_T2_DUTY_CAPTURE,
  input  wire tsc_run_t     I_RUN_HW_CLR,
  output tsc_run_t          O_RUN,
  output tsc_reload_t       O_RELOAD,
  output logic              O_T2_LOW_GATE,
  output logic              O_T2_HIGH_GATE,
  output logic [7:0]        O_SFR_RDATA
);

  tsc_state_t state_q;
  tsc_state_t state_d;

  logic       hit_start;
  logic       hit_reload;
  logic       hit_stop;
  logic [3:0] start_set;
  logic [3:0] stop_clr;
  logic [3:0] reload_set;
  logic [3:0] run_n;

  // decode the three strobe registers sharing one address on separate pages
  assign hit_start  = I_SFR_REQ.addr == `TSC_ADDR_STRB && I_SFR_REQ.page == `TSC_PAGE_START;
  assign hit_reload = I_SFR_REQ.addr == `TSC_ADDR_STRB && I_SFR_REQ.page == `TSC_PAGE_RELOAD;
  assign hit_stop   = I_SFR_REQ.addr == `TSC_ADDR_STRB && I_SFR_REQ.page == `TSC_PAGE_STOP;

  always_comb begin
    start_set  = 4'h0;
    stop_clr   = 4'h0;
    reload_set = 4'h0;
    // reserved bits are not looked at, so stray ones do no harm [R8] [R9]
    if (I_SFR_REQ.wr && hit_start) begin
      // one decode for all bits so a multi-bit write starts them together [R7]
      start_set[0] = I_SFR_REQ.wdata[`TSC_BIT_T0];                 // [R1] [R6]
      start_set[1] = I_SFR_REQ.wdata[`TSC_BIT_T1];                 // [R2] [R6]
      start_set[2] = I_SFR_REQ.wdata[`TSC_BIT_T2];                 // [R3] [R6]
      start_set[3] = I_SFR_REQ.wdata[`TSC_BIT_T2L] && I_T2_SPLIT;  // [R4]
    end
    if (I_SFR_REQ.wr && hit_stop) begin
      stop_clr[0] = I_SFR_REQ.wdata[`TSC_BIT_T0];                  // [R18] [R6]
      stop_clr[1] = I_SFR_REQ.wdata[`TSC_BIT_T1];                  // [R17]
      stop_clr[2] = I_SFR_REQ.wdata[`TSC_BIT_T2];                  // [R16]
      stop_clr[3] = I_SFR_REQ.wdata[`TSC_BIT_T2L] && I_T2_SPLIT;   // [R15]
    end
    if (I_SFR_REQ.wr && hit_reload) begin
      reload_set[0] = I_SFR_REQ.wdata[`TSC_BIT_T0];                // [R14] [R6]
      reload_set[1] = I_SFR_REQ.wdata[`TSC_BIT_T1];                // [R13]
      // duty capture owns the timer-2 count, so forced reloads are dropped
      reload_set[2] = I_SFR_REQ.wdata[`TSC_BIT_T2] && !I_T2_DUTY_CAPTURE;  // [R11] [R12]
      reload_set[3] = I_SFR_REQ.wdata[`TSC_BIT_T2L] && I_T2_SPLIT
                      && !I_T2_DUTY_CAPTURE;                       // [R10] [R12]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_run
      // a software start wins over a hardware clear in the same cycle
      assign run_n[g] = start_set[g] ? 1'b1 :
                        (stop_clr[g] || I_RUN_HW_CLR.run[g]) ? 1'b0 :
                        state_q.run.run[g];                        // [R1] [R7] [R21]
    end
  endgenerate

  always_comb begin
    state_d              = state_q;
    state_d.run.run      = run_n;
    // reload pulses live one cycle only; the strobes never hold a value [R5]
    state_d.rld.reload   = reload_set;                             // [R21]
    // high byte follows the timer-2 run bit; low byte has its own when split
    state_d.t2_high_gate = run_n[2];                               // [R20]
    state_d.t2_low_gate  = I_T2_SPLIT ? run_n[3] : run_n[2];       // [R19]
    // strobe registers read as zero; unmapped reads also give zero
    state_d.rdata        = `TSC_RST_STRB;                          // [R22]
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_q.run.run      <= `TSC_RST_RUN;
      state_q.rld.reload   <= 4'h0;
      state_q.t2_low_gate  <= 1'b0;
      state_q.t2_high_gate <= 1'b0;
      state_q.rdata        <= `TSC_RST_STRB;
    end else begin
      state_q <= state_d;
    end
  end

  assign O_RUN          = state_q.run;
  assign O_RELOAD       = state_q.rld;
  assign O_T2_LOW_GATE  = state_q.t2_low_gate;
  assign O_T2_HIGH_GATE = state_q.t2_high_gate;
  assign O_SFR_RDATA    = state_q.rdata;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  logic wr_start;
  logic wr_stop;
  logic wr_reload;
  assign wr_start  = I_SFR_REQ.wr && hit_start;
  assign wr_stop   = I_SFR_REQ.wr && hit_stop;
  assign wr_reload = I_SFR_REQ.wr && hit_reload;

  a_start_t0_sets: assert property (wr_start && I_SFR_REQ.wdata[0] |=> O_RUN.run[0]) // [R1]
    else $error("timer-0 start strobe did not set run bit");
  a_start_t1_sets: assert property (wr_start && I_SFR_REQ.wdata[1] |=> O_RUN.run[1]) // [R2]
    else $error("timer-1 start strobe did not set run bit");
  a_start_t2_sets: assert property (wr_start && I_SFR_REQ.wdata[2] |=> O_RUN.run[2]) // [R3]
    else $error("timer-2 start strobe did not set run bit");
  a_start_low_half: assert property (wr_start && I_SFR_REQ.wdata[5] && I_T2_SPLIT |=> O_RUN.run[3]) // [R4]
    else $error("low half start strobe did not set run bit");
  a_reload_pulse_once: assert property (O_RELOAD.reload != 4'h0 && !wr_reload |=> O_RELOAD.reload == 4'h0) // [R5]
    else $error("reload pulse held longer than one cycle");
  a_zero_write_keeps: assert property (wr_start && I_SFR_REQ.wdata[2:0] == 3'h0 && !wr_stop
                                        && I_RUN_HW_CLR.run[2:0] == 3'h0
                                        |=> O_RUN.run[2:0] == $past(O_RUN.run[2:0])) // [R6]
    else $error("zero start write changed a run bit");
  a_start_together: assert property (wr_start && I_SFR_REQ.wdata[2:0] == 3'h7 |=> O_RUN.run[2:0] == 3'h7) // [R7]
    else $error("simultaneous start did not start all timers");
  a_low_reload_split: assert property (wr_reload && I_SFR_REQ.wdata[5]
                                        |=> O_RELOAD.reload[3] == ($past(I_T2_SPLIT)
                                        && !$past(I_T2_DUTY_CAPTURE))) // [R10]
    else $error("low half reload not tied to split mode");
  a_t2_reload_force: assert property (wr_reload && I_SFR_REQ.wdata[2] && !I_T2_DUTY_CAPTURE
                                       |=> O_RELOAD.reload[2]) // [R11]
    else $error("timer-2 reload strobe did not pulse");
  a_duty_blocks_rld: assert property (wr_reload && I_T2_DUTY_CAPTURE |=> O_RELOAD.reload[3:2] == 2'b00) // [R12]
    else $error("forced reload taken in duty capture mode");
  a_t1_reload_force: assert property (wr_reload && I_SFR_REQ.wdata[1] |=> O_RELOAD.reload[1]) // [R13]
    else $error("timer-1 reload strobe did not pulse");
  a_t0_reload_force: assert property (wr_reload && I_SFR_REQ.wdata[0] |=> O_RELOAD.reload[0]) // [R14]
    else $error("timer-0 reload strobe did not pulse");
  a_stop_low_half: assert property (wr_stop && I_SFR_REQ.wdata[5] && I_T2_SPLIT && !wr_start
                                     |=> !O_RUN.run[3]) // [R15]
    else $error("low half stop strobe did not clear run bit");
  a_stop_t2_clears: assert property (wr_stop && I_SFR_REQ.wdata[2] |=> !O_RUN.run[2]) // [R16]
    else $error("timer-2 stop strobe did not clear run bit");
  a_stop_t1_clears: assert property (wr_stop && I_SFR_REQ.wdata[1] |=> !O_RUN.run[1]) // [R17]
    else $error("timer-1 stop strobe did not clear run bit");
  a_stop_t0_clears: assert property (wr_stop && I_SFR_REQ.wdata[0] |=> !O_RUN.run[0]) // [R18]
    else $error("timer-0 stop strobe did not clear run bit");
  a_split_low_gate: assert property (I_T2_SPLIT ##1 1'b1 |-> O_T2_LOW_GATE == O_RUN.run[3]) // [R19]
    else $error("split low byte gate not from low half run bit");
  a_high_gate_run: assert property (O_T2_HIGH_GATE == O_RUN.run[2]) // [R20]
    else $error("high byte gate differs from timer-2 run bit");
  a_reload_keeps_run: assert property (wr_reload && !wr_start && !wr_stop && I_RUN_HW_CLR.run == 4'h0
                                        |=> O_RUN == $past(O_RUN)) // [R21]
    else $error("forced reload changed a run bit");
  a_read_zero: assert property (O_SFR_RDATA == 8'h00) // [R22]
    else $error("strobe register read not zero");

endmodule

// [tsc_timer_sync_tb.sv]
// self-checking bench for the timer synchronous control block
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_timer_sync_tb;
  import tsc_pkg::*;
  logic         clk = 1'b0, rst = 1'b1, split = 1'b0, duty = 1'b0, lg, hg;
  tsc_sfr_req_t req = '0;
  tsc_run_t     hw_clr = '0;
  tsc_run_t     run;
  tsc_reload_t  rld;
  logic [7:0]   rdata;
  logic [15:0]  c0, c2;
  int           err_total = 0, n_compared = 0;

  always #50 clk = ~clk;

  tsc_timer_sync DUT (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_SFR_REQ(req), .I_T2_SPLIT(split),
    .I_T2_DUTY_CAPTURE(duty), .I_RUN_HW_CLR(hw_clr), .O_RUN(run), .O_RELOAD(rld),
    .O_T2_LOW_GATE(lg), .O_T2_HIGH_GATE(hg), .O_SFR_RDATA(rdata));
  tsc_timer_model #(.RLD_VAL(16'h1234)) MODEL (.i_clk(clk), .i_rst(rst), .i_run(run), .i_reload(rld),
    .i_split(split), .i_low_gate(lg), .i_high_gate(hg), .o_cnt_t0(c0), .o_cnt_t2(c2));

  // request raised just after an edge, taken at the next one
  task put(input logic [3:0] pg, input logic [7:0] d, input logic rd = 1'b0);
    @(posedge clk);
    req <= '{wr: !rd, rd: rd, page: pg, addr: `TSC_ADDR_STRB, wdata: d};
  endtask
  task idle;
    @(posedge clk);
    req <= '0;
    hw_clr <= '0;
    #1;
  endtask
  task wr(input logic [3:0] pg, input logic [7:0] d);
    put(pg, d);
    idle;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (400) @(posedge clk);
    err_total++;
    conclude;
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    idle;
    chk("run after reset", 16'h0, {12'h0, run.run});
    wr(`TSC_PAGE_START, 8'h07);
    chk("run multi start", 16'h7, {12'h0, run.run});
    chk("gates unsplit", 16'h3, {14'h0, lg, hg});
    chk("reload idle", 16'h0, {12'h0, rld.reload});
    wr(`TSC_PAGE_START, 8'h20); // bit5 has no effect unless split
    wr(`TSC_PAGE_START, 8'hD8); // reserved bits only, refused
    wr(`TSC_PAGE_STOP, 8'h00);
    put(`TSC_PAGE_RELOAD, 8'h00);
    idle;
    chk("zero writes reload", 16'h0, {12'h0, rld.reload});
    chk("zero writes run", 16'h7, {12'h0, run.run});
    @(posedge clk) split <= 1'b1;
    wr(`TSC_PAGE_START, 8'h20);
    chk("low half start", 16'hF, {12'h0, run.run});
    wr(`TSC_PAGE_STOP, 8'h04);
    chk("t2 stop", 16'hB, {12'h0, run.run});
    chk("split gates", 16'h2, {14'h0, lg, hg});
    wr(`TSC_PAGE_STOP, 8'h20);
    chk("low half stop", 16'h3, {12'h0, run.run});
    put(`TSC_PAGE_RELOAD, 8'h27);
    idle;
    chk("reload split", 16'hF, {12'h0, rld.reload});
    idle;
    chk("reload one cycle", 16'h0, {12'h0, rld.reload});
    chk("run kept on reload", 16'h3, {12'h0, run.run});
    chk("t0 count reloaded", 16'h1234, c0);
    chk("t2 count reloaded", 16'h1234, c2);
    wr(`TSC_PAGE_STOP, 8'h03);
    chk("t0 t1 stop", 16'h0, {12'h0, run.run});
    @(posedge clk) split <= 1'b0;
    put(`TSC_PAGE_RELOAD, 8'h27);
    idle;
    chk("reload unsplit", 16'h7, {12'h0, rld.reload});
    @(posedge clk) duty <= 1'b1;
    put(`TSC_PAGE_RELOAD, 8'h27);
    idle;
    chk("reload in duty capture", 16'h3, {12'h0, rld.reload});
    duty <= 1'b0;
    put(`TSC_PAGE_START, 8'h01);
    put(`TSC_PAGE_STOP, 8'h01);
    #1;
    chk("back to back start", 16'h1, {12'h0, run.run});
    idle;
    chk("back to back stop", 16'h0, {12'h0, run.run});
    wr(`TSC_PAGE_START, 8'h02);
    put(`TSC_PAGE_START, 8'h05);
    hw_clr.run <= 4'h6; // clear on t2 loses to its start, t1 is cleared
    idle;
    chk("hw clear priority", 16'h5, {12'h0, run.run});
    for (int p = 1; p <= 3; p++) begin
      put(p[3:0], 8'h00, 1'b1);
      idle;
      chk("strobe readback", 16'h0, {8'h0, rdata});
    end
    conclude;
  end
endmodule
